// >>> cm_pkg.sv
`default_nettype none
package cm_pkg;

   localparam logic [7:0] CM_SFR_ADDR = 8'h97;
   localparam logic [7:0] CM_SFR_PAGE = 8'h0f;
   localparam logic [7:0] CM_REG_RESET = 8'h00;

   localparam int CM_EN_BIT = 7;
   localparam int CM_INIT_BIT = 6;
   localparam int CM_RDY_BIT = 5;
   localparam int CM_SCALE_LSB = 2;
   localparam int CM_SCALE_MSB = 4;
   localparam int CM_SEL_LSB = 0;
   localparam int CM_SEL_MSB = 1;
   localparam int CM_SEL_EXT_BIT = 0;
   localparam int CM_SEL_X4_BIT = 1;

   localparam logic [1:0] CM_SEL_INT_X2 = 2'h0;
   localparam logic [1:0] CM_SEL_EXT_X2 = 2'h1;
   localparam logic [1:0] CM_SEL_INT_X4 = 2'h2;
   localparam logic [1:0] CM_SEL_EXT_X4 = 2'h3;

   localparam logic [2:0] CM_BURST_X2 = 3'h2;
   localparam logic [2:0] CM_BURST_X4 = 3'h4;
   localparam logic [3:0] CM_SCALE_STEP = 4'h2;
   localparam logic [3:0] CM_DEN_BYPASS = 4'h0;

   localparam int CM_LOCK_EDGES = 16;

   typedef struct packed {
      logic en;
      logic init;
      logic [2:0] scale;
      logic [1:0] sel;
   } cm_cfg_t;

   typedef enum logic [1:0] {CM_IDLE, CM_LOCKING, CM_LOCKED} cm_lock_state_t;

   typedef struct packed {
      cm_cfg_t cfg;
      logic ready;
      cm_lock_state_t lst;
      logic [7:0] edge_cnt;
      logic [1:0] int_sync;
      logic [1:0] ext_sync;
      logic ref_prev;
      logic [2:0] burst_left;
      logic tick;
      logic [7:0] rdata;
   } cm_ctrl_state_t;

   typedef struct packed {
      logic [3:0] acc;
      logic tick;
      logic uneven;
   } cm_scale_state_t;

   // denominator of the 2/n factor; bypass means factor 1
   function automatic logic [3:0] cm_scale_den(input logic [2:0] code);
      logic [3:0] den;
      den = CM_DEN_BYPASS;
      case (code)
         3'h1: den = 4'h3;
         3'h2: den = 4'h4;
         3'h3: den = 4'h5;
         3'h4: den = 4'h6;
         3'h5: den = 4'h7;
         default: den = CM_DEN_BYPASS;
      endcase
      return den;
   endfunction

endpackage
`default_nettype wire

// >>> cm_scaler.sv
`timescale 1ns/1ns
`default_nettype none
module cm_scaler (
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   input wire logic tick_in,
   input wire logic x4_in,
   input wire logic [2:0] scale_in,
   output logic tick_out,
   output logic uneven_duty_out
);
   import cm_pkg::*;

   cm_scale_state_t s;
   cm_scale_state_t next_s;
   logic [3:0] den;
   logic [3:0] sum;

   always_comb begin
      next_s = s;
      // x2 bases ignore the scale field
      den = x4_in ? cm_scale_den(scale_in) : CM_DEN_BYPASS;
      sum = s.acc + CM_SCALE_STEP;
      // odd denominators cannot give half high, half low
      next_s.uneven = den[0];
      next_s.tick = 1'b0;
      if (tick_in) begin
         if (den == CM_DEN_BYPASS) begin
            next_s.tick = 1'b1;
         end else if (sum >= den) begin
            // two in, one out per n: factor 2/n
            next_s.tick = 1'b1;
            next_s.acc = sum - den;
         end else begin
            next_s.acc = sum;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick_out = s.tick;
   assign uneven_duty_out = s.uneven;

   chk_x2_unscaled: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (!x4_in && tick_in) |=> s.tick)
      else $error("x2 base tick was scaled");

   chk_two_thirds: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (x4_in && scale_in == 3'h1 && tick_in && s.acc == 4'h2) |=> (s.tick && s.acc == 4'h1))
      else $error("2/3 scaling step wrong");

   chk_uneven_duty: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (x4_in && (scale_in == 3'h1 || scale_in == 3'h3 || scale_in == 3'h5))
      ##1 (x4_in && $stable(scale_in))
      |-> s.uneven)
      else $error("odd divide not flagged uneven");

endmodule
`default_nettype wire

// >>> cm_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - init starts lock only if written one while enable already set
// - ready reads one only after the loop has locked
// - select 00 int x2, 01 ext x2, 10 int x4, 11 ext x4
// - with an x2 base the scale field is ignored
// - some scale settings give a duty cycle other than half
// - scale gives 1, 2/3, 2/4, 2/5, 2/6 or 2/7 of the x4 base
// - slow input yields bursts of fast pulses per input rising edge
module cm_ctrl #(
   parameter int LOCK_EDGES = cm_pkg::CM_LOCK_EDGES
) (
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_page_in,
   input wire logic sfr_wr_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic sfr_rd_in,
   output logic [7:0] sfr_rdata_out,
   input wire logic int_osc_in,
   input wire logic ext_osc_in,
   output logic mult_enable_out,
   output logic mult_ready_out,
   output logic mult_tick_out,
   output logic uneven_duty_out
);
   import cm_pkg::*;

   if (LOCK_EDGES < 1 || LOCK_EDGES > 255) begin : g_bad_lock_edges
      $error("LOCK_EDGES must lie in 1..255");
   end

   localparam logic [7:0] LAST_EDGE = 8'(LOCK_EDGES - 1);

   cm_ctrl_state_t s;
   cm_ctrl_state_t next_s;
   logic sel_hit;
   logic wr_hit;
   logic init_req;
   logic ref_lvl;
   logic ref_rise;

   always_comb begin
      next_s = s;
      // oscillators are foreign to clk_sys; two flops before any use
      next_s.int_sync = {s.int_sync[0], int_osc_in};
      next_s.ext_sync = {s.ext_sync[0], ext_osc_in};

      // source choice by the low select bit
      ref_lvl = s.cfg.sel[CM_SEL_EXT_BIT] ? s.ext_sync[1] : s.int_sync[1];
      ref_rise = ref_lvl && !s.ref_prev;
      next_s.ref_prev = ref_lvl;

      sel_hit = (sfr_addr_in == CM_SFR_ADDR) && (sfr_page_in == CM_SFR_PAGE);
      wr_hit = sfr_wr_in && sel_hit;
      // enable must already be stored, not arriving in the same write
      init_req = wr_hit && sfr_wdata_in[CM_INIT_BIT] && s.cfg.en;

      if (wr_hit) begin
         next_s.cfg.en = sfr_wdata_in[CM_EN_BIT];
         next_s.cfg.init = sfr_wdata_in[CM_INIT_BIT];
         next_s.cfg.scale = sfr_wdata_in[CM_SCALE_MSB:CM_SCALE_LSB];
         next_s.cfg.sel = sfr_wdata_in[CM_SEL_MSB:CM_SEL_LSB];
      end

      case (s.lst)
         CM_IDLE: begin
            if (init_req) begin
               next_s.lst = CM_LOCKING;
               next_s.edge_cnt = '0;
            end
         end
         CM_LOCKING: begin
            if (init_req) begin
               next_s.edge_cnt = '0;
            end else if (ref_rise) begin
               if (s.edge_cnt == LAST_EDGE) begin
                  next_s.lst = CM_LOCKED;
                  next_s.ready = 1'b1;
               end else begin
                  next_s.edge_cnt = s.edge_cnt + 8'h01;
               end
            end
         end
         CM_LOCKED: begin
            if (init_req) begin
               // re-init drops lock until acquired again
               next_s.lst = CM_LOCKING;
               next_s.ready = 1'b0;
               next_s.edge_cnt = '0;
            end
         end
         default: begin
            next_s.lst = CM_IDLE;
            next_s.ready = 1'b0;
         end
      endcase

      // disable or zero write beats a lock completing in the same cycle
      if (!next_s.cfg.en) begin
         next_s.lst = CM_IDLE;
         next_s.ready = 1'b0;
         next_s.edge_cnt = '0;
      end

      // each reference edge while enable is stored gives a burst of 2 or 4 fast ticks
      next_s.tick = (s.burst_left != 3'h0);
      if (s.burst_left != 3'h0) begin
         next_s.burst_left = s.burst_left - 3'h1;
      end
      if (ref_rise && s.cfg.en) begin
         // x2 or x4 by the high select bit
         next_s.burst_left = s.cfg.sel[CM_SEL_X4_BIT] ? CM_BURST_X4 : CM_BURST_X2;
      end

      // ready is read-only; written bit 5 never reaches it, only disable or init clear it
      next_s.rdata = 8'h00;
      if (sfr_rd_in && sel_hit) begin
         next_s.rdata = {s.cfg.en, s.cfg.init, s.ready, s.cfg.scale, s.cfg.sel};
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   cm_scaler u_scaler (
      .clk_sys_in(clk_sys_in),
      .rstn_in(rstn_in),
      .tick_in(s.tick),
      .x4_in(s.cfg.sel[CM_SEL_X4_BIT]),
      .scale_in(s.cfg.scale),
      .tick_out(mult_tick_out),
      .uneven_duty_out(uneven_duty_out)
   );

   assign sfr_rdata_out = s.rdata;
   assign mult_enable_out = s.cfg.en;
   assign mult_ready_out = s.ready;

   chk_init_needs_en: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      $rose(s.lst == CM_LOCKING) |-> $past(s.cfg.en))
      else $error("lock began without prior enable");

   chk_ready_locked: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      s.ready == (s.lst == CM_LOCKED))
      else $error("ready disagrees with lock state");

   chk_ready_edges: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      $rose(s.ready) |-> ($past(s.lst) == CM_LOCKING && $past(s.edge_cnt) == LAST_EDGE))
      else $error("ready rose before lock edges counted");

   chk_x2_burst: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (ref_rise && s.cfg.en && !s.cfg.sel[CM_SEL_X4_BIT]) |=> s.burst_left == CM_BURST_X2)
      else $error("x2 burst length wrong");

   chk_x4_burst: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (s.burst_left == CM_BURST_X4) |=> s.tick [*4])
      else $error("x4 burst not four ticks");

   chk_zero_clears: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (wr_hit && sfr_wdata_in == CM_REG_RESET) |=> (!s.ready && s.lst == CM_IDLE)
         ##1 !s.ready)
      else $error("zero write left ready set");

   chk_read_image: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (sfr_rd_in && sel_hit && s.ready) |=> s.rdata[CM_RDY_BIT])
      else $error("ready bit not read back");

   // ready may only be set while enable is stored
   chk_ready_needs_en: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      s.ready |-> s.cfg.en)
      else $error("ready set while disabled");

   chk_disable_clears: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (wr_hit && !sfr_wdata_in[CM_EN_BIT]) |=> (!s.ready && s.lst == CM_IDLE))
      else $error("disable write left lock state");

   chk_idle_stays: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (s.lst == CM_IDLE && !init_req) |=> (s.lst == CM_IDLE))
      else $error("lock began without init request");

   chk_init_restart: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (init_req && sfr_wdata_in[CM_EN_BIT]) |=> (s.lst == CM_LOCKING && s.edge_cnt == 8'h00 && !s.ready))
      else $error("init did not restart locking");

   chk_rdata_idle: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      !(sfr_rd_in && sel_hit) |=> (s.rdata == 8'h00))
      else $error("read data without a read");

   chk_idle_write_no_ready: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (wr_hit && s.lst == CM_IDLE) |=> !s.ready)
      else $error("write set the ready flag");

   chk_lock_holds: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (s.lst == CM_LOCKED && !wr_hit) |=> s.ready)
      else $error("ready dropped without a write");

   chk_edge_bound: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      s.edge_cnt <= LAST_EDGE)
      else $error("lock edge count out of range");

   chk_burst_bound: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      s.burst_left <= CM_BURST_X4)
      else $error("burst length out of range");

   chk_x2_ticks: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      (s.burst_left == CM_BURST_X2) |=> s.tick [*2])
      else $error("x2 burst not two ticks");

endmodule
`default_nettype wire

// >>> cm_osc_model.sv
`timescale 1ns/1ns
`default_nettype none
module cm_osc_model #(
   parameter int INT_HALF = 6,
   parameter int EXT_HALF = 7
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   output logic int_osc_out,
   output logic ext_osc_out
);
   int ci;
   int ce;
   // free running from reset on, so ext is stable long before init
   // x4 of these periods stays below the 50 MHz ceiling
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         ci <= 0;
         ce <= 0;
         int_osc_out <= 1'b0;
         ext_osc_out <= 1'b0;
      end else begin
         ci <= (ci == INT_HALF - 1) ? 0 : ci + 1;
         ce <= (ce == EXT_HALF - 1) ? 0 : ce + 1;
         if (ci == INT_HALF - 1) int_osc_out <= ~int_osc_out;
         if (ce == EXT_HALF - 1) ext_osc_out <= ~ext_osc_out;
      end
   end
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import cm_pkg::*;
   localparam int WIN = 420;
   logic clk_sys_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] page = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   wire logic [7:0] rdata;
   wire logic en_o, rdy_o, tick_o, uneven_o, int_osc, ext_osc;
   int fail_count = 0;
   int checks = 0;
   int cyc = 0;

   cm_osc_model cm_osc_model_inst (.clk_in(clk_sys_in), .rstn_in(rstn_in),
      .int_osc_out(int_osc), .ext_osc_out(ext_osc));
   cm_ctrl #(.LOCK_EDGES(2)) cm_ctrl_inst (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
      .sfr_addr_in(addr), .sfr_page_in(page), .sfr_wr_in(wr), .sfr_wdata_in(wdata),
      .sfr_rd_in(rd), .sfr_rdata_out(rdata), .int_osc_in(int_osc), .ext_osc_in(ext_osc),
      .mult_enable_out(en_o), .mult_ready_out(rdy_o), .mult_tick_out(tick_o),
      .uneven_duty_out(uneven_o));

   initial begin
      forever #5 clk_sys_in = ~clk_sys_in;
   end

   task automatic conclude();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 90000) begin
         fail_count++;
         conclude();
      end
   end

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys_in);
      addr = a;
      page = CM_SFR_PAGE;
      wdata = d;
      wr = 1'b1;
      @(negedge clk_sys_in);
      wr = 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, input logic [7:0] pg, output logic [7:0] d);
      @(negedge clk_sys_in);
      addr = a;
      page = pg;
      rd = 1'b1;
      @(negedge clk_sys_in);
      rd = 1'b0;
      d = rdata;
   endtask

   // tick count over WIN reference periods; bypass codes count as 2/2
   function automatic int exp_ticks(input logic [1:0] sel, input logic [2:0] sc);
      int den;
      den = (sc >= 3'h1 && sc <= 3'h5) ? int'(sc) + 2 : 2;
      return sel[1] ? WIN * 8 / den : WIN * 2;
   endfunction

   initial begin
      logic [7:0] d;
      logic [1:0] sel;
      logic [2:0] sc;
      int n;
      int e;
      void'($urandom(32'h05bcbf6e));
      repeat (8) @(negedge clk_sys_in);
      rstn_in = 1'b1;
      rd_reg(CM_SFR_ADDR, CM_SFR_PAGE, d);
      chk("reset image", 8'h00, d);
      wr_reg(8'h96, 8'($urandom));
      rd_reg(8'h96, CM_SFR_PAGE, d);
      chk("unmapped read", 8'h00, d);
      rd_reg(CM_SFR_ADDR, 8'h00, d);
      chk("wrong page read", 8'h00, d);
      wr_reg(CM_SFR_ADDR, 8'h7f);
      rd_reg(CM_SFR_ADDR, CM_SFR_PAGE, d);
      chk("image after 7f", 8'h5f, d);
      chk("rdata stands", 8'h5f, rdata);
      @(negedge clk_sys_in);
      chk("rdata returns", 8'h00, rdata);
      repeat (200) @(negedge clk_sys_in);
      chk("ready without enable", 1'b0, rdy_o);
      for (int i = 0; i < 10; i++) begin
         sel = (i < 8) ? {1'b1, i[0]} : {1'b0, i[0]};
         sc = (i < 8) ? 3'(i) : 3'($urandom);
         wr_reg(CM_SFR_ADDR, 8'h00);
         wr_reg(CM_SFR_ADDR, {6'h00, sel});
         wr_reg(CM_SFR_ADDR, {3'h0, sc, sel});
         wr_reg(CM_SFR_ADDR, {3'h4, sc, sel});
         chk("enable level", 1'b1, en_o);
         repeat (510) @(negedge clk_sys_in);
         wr_reg(CM_SFR_ADDR, {3'h6, sc, sel});
         chk("ready before lock", 1'b0, rdy_o);
         n = 0;
         while (rdy_o !== 1'b1 && n < 200) begin
            @(negedge clk_sys_in);
            n++;
         end
         chk("ready after lock", 1'b1, rdy_o);
         rd_reg(CM_SFR_ADDR, CM_SFR_PAGE, d);
         chk("locked image", {3'h7, sc, sel}, d);
         chk("duty flag", sel[1] && (sc == 3'h1 || sc == 3'h3 || sc == 3'h5), uneven_o);
         n = 0;
         e = exp_ticks(sel, sc);
         repeat (WIN * (sel[0] ? 14 : 12)) begin
            @(negedge clk_sys_in);
            if (tick_o === 1'b1) n++;
         end
         checks++;
         if (n < e - 1 || n > e + 1) begin
            fail_count++;
            $display("wrong value tick count expected %0d seen %0d", e, n);
         end
      end
      wr_reg(CM_SFR_ADDR, {3'h6, sc, sel});
      chk("ready after re-init", 1'b0, rdy_o);
      repeat (100) @(negedge clk_sys_in);
      chk("ready after relock", 1'b1, rdy_o);
      wr_reg(CM_SFR_ADDR, 8'h43);
      chk("ready after disable", 1'b0, rdy_o);
      wr_reg(CM_SFR_ADDR, 8'hc3);
      repeat (100) @(negedge clk_sys_in);
      chk("enable and init together", 1'b0, rdy_o);
      wr_reg(CM_SFR_ADDR, 8'h00);
      rd_reg(CM_SFR_ADDR, CM_SFR_PAGE, d);
      chk("cleared image", 8'h00, d);
      conclude();
   end
endmodule
`default_nettype wire
